//--- verilog/usp_uart.sv
// Full-duplex serial port with low-power receive and DMA requests
`default_nettype none
// What this block does
// - Transmit and receive paths run at once, fully independent.
// - Each instance has its own configuration inputs and state.
// - Receiver keeps running in sleep, deep and backup modes up to 9600 baud.
// - In low power, valid characters enter the FIFO; enabled conditions wake.
// - Wake-up is selectable on several receive FIFO conditions.
// - Fractional divisor adds sixteenths of a cycle for low-rate accuracy.
// - Active mode reaches 2.5 Mbps with the smallest divider.
// - Character width selects 5 to 8 data bits.
// - Five-bit characters take 1 or 1.5 stop bits, others 1 or 2.
// - Parity is none, even, odd, mark or space.
// - Receiver flags parity errors, with bias, and frame errors.
// - Separate eight-byte transmit and receive FIFOs.
// - With flow control on, RTS and CTS pace characters both ways.
// - Separate DMA requests for receive and transmit FIFOs.
// - Each DMA channel has its own enable, set high to enable.
// - DMA requests only in active or sleep power modes.
// - Receive request when receive level reaches the threshold or above.
// - Transmit request when transmit level falls below the threshold.
// - Writes to a full transmit FIFO are ignored, level unchanged.
// - A valid frame arriving with receive FIFO full is dropped, overrun flagged.
module usp_uart
  import usp_pkg::*;
#(
  parameter int DEPTH = USP_FIFO_DEPTH,
  parameter bit LP_VARIANT = 1'b1
) (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic [15:0] I_BAUD_DIV,
  input wire logic I_FRAC_EN,
  input wire logic [3:0] I_FRAC,
  input wire usp_pkg::usp_char_t I_CHAR_SIZE,
  input wire logic I_STOP_LONG,
  input wire usp_pkg::usp_par_t I_PARITY,
  input wire logic I_PAR_BIAS,
  input wire usp_pkg::usp_pwr_t I_PWR_MODE,
  input wire logic [2:0] I_WAKE_EN,
  output logic O_WAKE,
  input wire logic I_HFC_EN,
  input wire logic I_CTS_N,
  output logic O_RTS_N,
  input wire logic I_RXD,
  output logic O_TXD,
  input wire logic I_TX_VALID,
  output logic O_TX_READY,
  input wire logic [7:0] I_TX_DATA,
  output logic O_RX_VALID,
  input wire logic I_RX_READY,
  output logic [7:0] O_RX_DATA,
  output logic O_RX_PERR,
  input wire logic I_TX_FLUSH,
  input wire logic I_RX_FLUSH,
  output logic [3:0] O_TX_LVL,
  output logic [3:0] O_RX_LVL,
  input wire logic [3:0] I_TX_THD,
  input wire logic [3:0] I_RX_THD,
  input wire logic I_DMA_TX_EN,
  input wire logic I_DMA_RX_EN,
  output logic O_DMA_TX_REQ,
  output logic O_DMA_RX_REQ,
  output logic O_RX_FERR_EV,
  output logic O_RX_PERR_EV,
  output logic O_RX_OVR_EV,
  output logic O_CTS_EV
);
  import usp_pkg::*;

  logic rxd_m_q, rxd_q, cts_m_q, cts_q, cts_old_q;
  logic [15:0] div_cnt_q;
  logic [3:0] acc_q;
  logic stretch_q, tick;
  logic [4:0] carry;
  usp_st_t rx_st_q, tx_st_q;
  logic [2:0] rx_ph_q, rx_bit_q, rx_smp_q, tx_bit_q;
  logic [7:0] rx_sr_q, tx_sr_q;
  logic rx_ferr_q, rx_par_q, tx_par_q;
  logic [4:0] tx_cnt_q, stop_ticks;
  logic [2:0] last_bit;
  logic maj, all0, all1;
  logic rx_done, rx_push, rx_push_rdy, tx_pop, tx_ok, low_pwr, dma_ok;
  logic [7:0] rx_data, tx_fifo_data;
  logic tx_fifo_valid, rxf_valid, rxf_take;
  logic [8:0] rxf_data;
  logic [3:0] rx_lvl, tx_lvl, rx_lvl_old_q, tx_lvl_old_q;
  logic exp_par_rx, exp_par_tx;

  // Pins from the outside pass two flops before use
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      rxd_m_q <= 1'b1;
      rxd_q <= 1'b1;
      cts_m_q <= 1'b1;
      cts_q <= 1'b1;
      cts_old_q <= 1'b1;
    end
    else
    begin
      rxd_m_q <= I_RXD;
      rxd_q <= rxd_m_q;
      cts_m_q <= I_CTS_N;
      cts_q <= cts_m_q;
      cts_old_q <= cts_q;
    end
  end

  // Oversample divider; fractional mode stretches some periods
  assign carry = {1'b0, acc_q} + {1'b0, I_FRAC};
  assign tick = (div_cnt_q <= 16'h0001) && !stretch_q;
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      div_cnt_q <= USP_DIV_MIN;
      acc_q <= '0;
      stretch_q <= 1'b0;
    end
    else if (stretch_q)
      stretch_q <= 1'b0;
    else if (tick)
    begin
      div_cnt_q <= (I_BAUD_DIV < USP_DIV_MIN) ? USP_DIV_MIN : I_BAUD_DIV;
      if (LP_VARIANT && I_FRAC_EN)
      begin
        acc_q <= carry[3:0];
        stretch_q <= carry[4];
      end
    end
    else
      div_cnt_q <= div_cnt_q - 16'h0001;
  end

  // Width, stop length and parity helpers
  assign last_bit = {1'b1, I_CHAR_SIZE};
  always_comb
  begin
    if (!I_STOP_LONG)
      stop_ticks = USP_STOP_1;
    else if (I_CHAR_SIZE == USP_CHAR_5)
      stop_ticks = USP_STOP_15;
    else
      stop_ticks = USP_STOP_2;
  end
  // Even parity over ones; bias counts zeros, which flips on odd widths
  function automatic logic par_bit(input logic [7:0] d, input usp_char_t cs, input usp_par_t pm,
                                   input logic bias);
    logic [7:0] m;
    logic p;
    m = 8'hff >> (3'h3 - 3'(cs));
    p = ^(d & m) ^ (bias & ~cs[0]);
    case (pm)
      USP_PAR_EVEN: par_bit = p;
      USP_PAR_ODD: par_bit = ~p;
      USP_PAR_MARK: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction
  assign rx_data = rx_sr_q >> (3'h3 - 3'(I_CHAR_SIZE));
  assign exp_par_rx = par_bit(rx_data, I_CHAR_SIZE, I_PARITY, I_PAR_BIAS);
  assign exp_par_tx = par_bit(tx_sr_q, I_CHAR_SIZE, I_PARITY, I_PAR_BIAS);

  // Three samples per bit, taken at the middle of the bit
  assign maj = (rx_smp_q[0] & rx_smp_q[1]) | (rx_smp_q[1] & rx_smp_q[2])
             | (rx_smp_q[0] & rx_smp_q[2]);
  assign all0 = rx_smp_q == 3'h0;
  assign all1 = rx_smp_q == 3'h7;
  assign rx_done = tick && (rx_st_q == USP_STOP) && (rx_ph_q == USP_BIT_LAST);

  // Receive state machine; runs in every power mode
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      rx_st_q <= USP_IDLE;
      rx_ph_q <= '0;
      rx_bit_q <= '0;
      rx_smp_q <= '0;
      rx_sr_q <= '0;
      rx_ferr_q <= 1'b0;
      rx_par_q <= 1'b0;
    end
    else if (tick)
    begin
      rx_ph_q <= rx_ph_q + 3'h1;
      if (rx_ph_q >= USP_SMP_FIRST && rx_ph_q <= USP_SMP_LAST)
        rx_smp_q <= {rx_smp_q[1:0], rxd_q};
      case (rx_st_q)
        USP_IDLE:
        begin
          rx_ph_q <= '0;
          rx_ferr_q <= 1'b0;
          rx_par_q <= 1'b0;
          if (!rxd_q)
            rx_st_q <= USP_START;
        end
        USP_START:
          if (rx_ph_q == USP_BIT_LAST)
          begin
            rx_bit_q <= '0;
            // Start bit must read low on all three samples
            rx_st_q <= all0 ? USP_DATA : USP_IDLE;
          end
        USP_DATA:
          if (rx_ph_q == USP_BIT_LAST)
          begin
            rx_sr_q <= {maj, rx_sr_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == last_bit)
              rx_st_q <= (I_PARITY == USP_PAR_NONE) ? USP_STOP : USP_PAR;
          end
        USP_PAR:
          if (rx_ph_q == USP_BIT_LAST)
          begin
            rx_ferr_q <= !(all0 || all1);
            rx_par_q <= maj != exp_par_rx;
            rx_st_q <= USP_STOP;
          end
        USP_STOP:
          if (rx_ph_q == USP_BIT_LAST)
          begin
            rx_ferr_q <= rx_ferr_q || !all1;
            rx_st_q <= USP_IDLE;
          end
        default:
          rx_st_q <= USP_IDLE;
      endcase
    end
  end

  // Frame outcome: framing-error frames dropped, parity-error frames kept, full FIFO gives overrun
  assign rx_push = rx_done && all1 && !rx_ferr_q;
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      O_RX_FERR_EV <= 1'b0;
      O_RX_PERR_EV <= 1'b0;
      O_RX_OVR_EV <= 1'b0;
      O_CTS_EV <= 1'b0;
    end
    else
    begin
      O_RX_FERR_EV <= (rx_done && (rx_ferr_q || !all1))
                    || (tick && rx_st_q == USP_START && rx_ph_q == USP_BIT_LAST && !all0);
      O_RX_PERR_EV <= rx_push && rx_push_rdy && rx_par_q;
      O_RX_OVR_EV <= rx_push && !rx_push_rdy;
      O_CTS_EV <= I_HFC_EN && (cts_q != cts_old_q);
    end
  end

  // Receive FIFO; parity error travels with its character
  usp_fifo #(.W(9), .DEPTH(DEPTH), .LW(USP_LVL_W)) u_rx_fifo (
    .i_clk(I_CLK),
    .i_rst_n(I_RESETN),
    .i_flush(I_RX_FLUSH),
    .i_wr_valid(rx_push),
    .o_wr_ready(rx_push_rdy),
    .i_wr_data({rx_par_q, rx_data}),
    .o_rd_valid(rxf_valid),
    .i_rd_ready(rxf_take),
    .o_rd_data(rxf_data),
    .o_level(rx_lvl)
  );

  // Output buffer so a stalled reader never loses a word
  usp_buf2 #(.W(9)) u_rx_buf (
    .i_clk(I_CLK),
    .i_rst_n(I_RESETN),
    .i_flush(I_RX_FLUSH),
    .i_valid(rxf_valid),
    .o_ready(rxf_take),
    .i_data(rxf_data),
    .o_valid(O_RX_VALID),
    .i_ready(I_RX_READY),
    .o_data({O_RX_PERR, O_RX_DATA})
  );

  // Transmit FIFO; ready low when full so extra writes are ignored
  usp_fifo #(.W(8), .DEPTH(DEPTH), .LW(USP_LVL_W)) u_tx_fifo (
    .i_clk(I_CLK),
    .i_rst_n(I_RESETN),
    .i_flush(I_TX_FLUSH),
    .i_wr_valid(I_TX_VALID),
    .o_wr_ready(O_TX_READY),
    .i_wr_data(I_TX_DATA),
    .o_rd_valid(tx_fifo_valid),
    .i_rd_ready(tx_pop),
    .o_rd_data(tx_fifo_data),
    .o_level(tx_lvl)
  );

  // New character only when clear to send and not in deep or backup power mode
  assign low_pwr = I_PWR_MODE == USP_PWR_DEEP || I_PWR_MODE == USP_PWR_BACKUP;
  assign tx_ok = !low_pwr && (!I_HFC_EN || !cts_q);
  assign tx_pop = tick && (tx_st_q == USP_IDLE) && tx_fifo_valid && tx_ok && !I_TX_FLUSH;

  // Transmit state machine, eight ticks per bit
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      tx_st_q <= USP_IDLE;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
      tx_sr_q <= '0;
      tx_par_q <= 1'b0;
      O_TXD <= 1'b1;
    end
    else if (tick)
    begin
      tx_cnt_q <= tx_cnt_q + 5'h01;
      case (tx_st_q)
        USP_IDLE:
        begin
          O_TXD <= 1'b1;
          tx_cnt_q <= '0;
          if (tx_pop)
          begin
            tx_sr_q <= tx_fifo_data;
            O_TXD <= 1'b0;
            tx_st_q <= USP_START;
          end
        end
        USP_START:
          if (tx_cnt_q[2:0] == USP_BIT_LAST)
          begin
            tx_par_q <= exp_par_tx;
            tx_bit_q <= '0;
            O_TXD <= tx_sr_q[0];
            tx_st_q <= USP_DATA;
          end
        USP_DATA:
          if (tx_cnt_q[2:0] == USP_BIT_LAST)
          begin
            tx_bit_q <= tx_bit_q + 3'h1;
            tx_sr_q <= {1'b0, tx_sr_q[7:1]};
            O_TXD <= tx_sr_q[1];
            if (tx_bit_q == last_bit)
            begin
              tx_cnt_q <= '0;
              O_TXD <= (I_PARITY == USP_PAR_NONE) ? 1'b1 : tx_par_q;
              tx_st_q <= (I_PARITY == USP_PAR_NONE) ? USP_STOP : USP_PAR;
            end
          end
        USP_PAR:
          if (tx_cnt_q[2:0] == USP_BIT_LAST)
          begin
            tx_cnt_q <= '0;
            O_TXD <= 1'b1;
            tx_st_q <= USP_STOP;
          end
        USP_STOP:
          if (tx_cnt_q == stop_ticks - 5'h01)
            tx_st_q <= USP_IDLE;
        default:
          tx_st_q <= USP_IDLE;
      endcase
    end
  end

  // Previous levels, for the threshold crossing requests
  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      rx_lvl_old_q <= '0;
      tx_lvl_old_q <= '0;
      O_DMA_RX_REQ <= 1'b0;
      O_DMA_TX_REQ <= 1'b0;
    end
    else
    begin
      rx_lvl_old_q <= rx_lvl;
      tx_lvl_old_q <= tx_lvl;
      // Raised on the crossing, held until the level moves back
      if (!(I_DMA_RX_EN && dma_ok) || rx_lvl < I_RX_THD)
        O_DMA_RX_REQ <= 1'b0;
      else if (rx_lvl != rx_lvl_old_q)
        O_DMA_RX_REQ <= 1'b1;
      if (!(I_DMA_TX_EN && dma_ok) || tx_lvl >= I_TX_THD)
        O_DMA_TX_REQ <= 1'b0;
      else if (tx_lvl != tx_lvl_old_q)
        O_DMA_TX_REQ <= 1'b1;
    end
  end
  assign dma_ok = I_PWR_MODE == USP_PWR_ACTIVE || I_PWR_MODE == USP_PWR_SLEEP;

  // Wake in any low-power mode on an enabled receive condition
  assign O_WAKE = LP_VARIANT && (I_PWR_MODE != USP_PWR_ACTIVE) && (
                  (I_WAKE_EN[USP_WAKE_NEMPTY] && rx_lvl != '0)
                  || (I_WAKE_EN[USP_WAKE_THD] && rx_lvl >= I_RX_THD)
                  || (I_WAKE_EN[USP_WAKE_FULL] && !rx_push_rdy));

  // Ask the far end to hold off once the receive FIFO is full
  assign O_RTS_N = I_HFC_EN && !rx_push_rdy;
  assign O_RX_LVL = rx_lvl;
  assign O_TX_LVL = tx_lvl;
endmodule
`default_nettype wire

//--- verilog/usp_pkg.sv
// Constants and types shared by the serial port files
`default_nettype none
package usp_pkg;
  localparam int USP_DW = 8;
  localparam int USP_FIFO_DEPTH = 8;
  localparam int USP_LVL_W = 4;
  localparam int USP_CLK_HZ = 20000000;
  localparam int USP_OVS = 8;
  localparam int USP_ACT_MAX_BPS = 1850000;
  localparam int USP_LP_MAX_BAUD = 9600;
  // Smallest divider that still reaches the fastest active rate
  localparam int USP_MIN_DIV = USP_CLK_HZ / (USP_ACT_MAX_BPS * USP_OVS);
  localparam logic [15:0] USP_DIV_MIN = 16'(USP_MIN_DIV);
  localparam logic [2:0] USP_SMP_FIRST = 3'h3;
  localparam logic [2:0] USP_SMP_LAST = 3'h5;
  localparam logic [2:0] USP_BIT_LAST = 3'h7;
  localparam logic [4:0] USP_STOP_1 = 5'h08;
  localparam logic [4:0] USP_STOP_15 = 5'h0c;
  localparam logic [4:0] USP_STOP_2 = 5'h10;
  localparam logic [3:0] USP_FRAC_ONE = 4'hf;
  localparam int USP_WAKE_NEMPTY = 0;
  localparam int USP_WAKE_THD = 1;
  localparam int USP_WAKE_FULL = 2;
  typedef enum logic [1:0] {
    USP_PWR_ACTIVE = 2'h0, USP_PWR_SLEEP = 2'h1, USP_PWR_DEEP = 2'h2, USP_PWR_BACKUP = 2'h3
  } usp_pwr_t;
  typedef enum logic [2:0] {
    USP_PAR_NONE = 3'h0, USP_PAR_EVEN = 3'h1, USP_PAR_ODD = 3'h2,
    USP_PAR_MARK = 3'h3, USP_PAR_SPACE = 3'h4
  } usp_par_t;
  typedef enum logic [1:0] {
    USP_CHAR_5 = 2'h0, USP_CHAR_6 = 2'h1, USP_CHAR_7 = 2'h2, USP_CHAR_8 = 2'h3
  } usp_char_t;
  typedef enum logic [4:0] {
    USP_IDLE = 5'h01, USP_START = 5'h02, USP_DATA = 5'h04, USP_PAR = 5'h08, USP_STOP = 5'h10
  } usp_st_t;
endpackage
`default_nettype wire

//--- verilog/usp_fifo.sv
// Synchronous FIFO with level count and flush
`default_nettype none
module usp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8,
  parameter int LW = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_flush,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [W-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [W-1:0] o_rd_data,
  output logic [LW-1:0] o_level
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [LW-1:0] cnt_q;
  logic wr;
  logic rd;

  // Writes while full are dropped here, leaving contents untouched
  assign o_wr_ready = cnt_q != LW'(DEPTH);
  assign o_rd_valid = cnt_q != '0;
  assign wr = i_wr_valid && o_wr_ready;
  assign rd = o_rd_valid && i_rd_ready;
  assign o_rd_data = mem_q[rp_q];
  assign o_level = cnt_q;

  // Pointers and count; flush empties without touching storage
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else if (i_flush)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (wr)
        wp_q <= (wp_q == LAST) ? '0 : wp_q + 1'b1;
      if (rd)
        rp_q <= (rp_q == LAST) ? '0 : rp_q + 1'b1;
      if (wr && !rd)
        cnt_q <= cnt_q + 1'b1;
      else if (rd && !wr)
        cnt_q <= cnt_q - 1'b1;
    end
  end

  // Storage has no reset; unread entries are never shown
  always_ff @(posedge i_clk)
  begin
    if (wr && !i_flush)
      mem_q[wp_q] <= i_wr_data;
  end
endmodule
`default_nettype wire

//--- verilog/usp_buf2.sv
// Two-entry buffer that absorbs a receiver stall
`default_nettype none
module usp_buf2 #(
  parameter int W = 9
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_flush,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  logic [W-1:0] d0_q;
  logic [W-1:0] d1_q;
  logic v0_q;
  logic v1_q;
  logic push;
  logic pop;

  assign o_ready = !v1_q;
  assign o_valid = v0_q;
  assign o_data = d0_q;
  assign push = i_valid && o_ready;
  assign pop = v0_q && i_ready;

  // Head and spare slot; the spare refills the head on a pop
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      d0_q <= '0;
      d1_q <= '0;
      v0_q <= 1'b0;
      v1_q <= 1'b0;
    end
    else if (i_flush)
    begin
      v0_q <= 1'b0;
      v1_q <= 1'b0;
    end
    else if (pop)
    begin
      if (v1_q)
      begin
        d0_q <= d1_q;
        v1_q <= 1'b0;
      end
      else if (push)
        d0_q <= i_data;
      else
        v0_q <= 1'b0;
      if (v1_q && push)
      begin
        d1_q <= i_data;
        v1_q <= 1'b1;
      end
    end
    else if (push)
    begin
      if (!v0_q)
      begin
        d0_q <= i_data;
        v0_q <= 1'b1;
      end
      else
      begin
        d1_q <= i_data;
        v1_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/usp_uart_monitor.sv
// Port-level checks for the serial port, bound to its top module
`default_nettype none
module usp_uart_monitor
  import usp_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire usp_pkg::usp_pwr_t I_PWR_MODE,
  input wire logic [2:0] I_WAKE_EN,
  input wire logic O_WAKE,
  input wire logic I_HFC_EN,
  input wire logic I_CTS_N,
  input wire logic O_RTS_N,
  input wire logic O_TXD,
  input wire logic O_TX_READY,
  input wire logic [3:0] O_TX_LVL,
  input wire logic [3:0] O_RX_LVL,
  input wire logic [3:0] I_TX_THD,
  input wire logic [3:0] I_RX_THD,
  input wire logic I_DMA_TX_EN,
  input wire logic I_DMA_RX_EN,
  input wire logic O_DMA_TX_REQ,
  input wire logic O_DMA_RX_REQ,
  input wire logic O_CTS_EV
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);
  // FIFO refusal, DMA requests, flow control, framing
  property p_tx_full;
    O_TX_LVL == 4'h8 |-> !O_TX_READY;
  endproperty
  a_tx_full: assert property (p_tx_full) else $error("tx ready while full");
  property p_rx_req;
    I_DMA_RX_EN && I_PWR_MODE inside {USP_PWR_ACTIVE, USP_PWR_SLEEP} && $changed(O_RX_LVL)
      && O_RX_LVL >= I_RX_THD |=> O_DMA_RX_REQ;
  endproperty
  a_rx_req: assert property (p_rx_req) else $error("rx request missing");
  property p_rx_off;
    !I_DMA_RX_EN |=> !O_DMA_RX_REQ;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx request while disabled");
  property p_rx_deep;
    I_PWR_MODE inside {USP_PWR_DEEP, USP_PWR_BACKUP} |=> !O_DMA_RX_REQ;
  endproperty
  a_rx_deep: assert property (p_rx_deep) else $error("rx request in low power");
  property p_tx_req;
    I_DMA_TX_EN && I_PWR_MODE inside {USP_PWR_ACTIVE, USP_PWR_SLEEP} && $changed(O_TX_LVL)
      && O_TX_LVL < I_TX_THD |=> O_DMA_TX_REQ;
  endproperty
  a_tx_req: assert property (p_tx_req) else $error("tx request missing");
  property p_rts;
    O_RTS_N == (I_HFC_EN && O_RX_LVL == 4'h8);
  endproperty
  a_rts: assert property (p_rts) else $error("rts level wrong");
  property p_wake;
    I_PWR_MODE != USP_PWR_ACTIVE && I_WAKE_EN[0] && O_RX_LVL != 4'h0 |-> O_WAKE;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missing");
  property p_start;
    $fell(O_TXD) |-> !O_TXD [*8];
  endproperty
  a_start: assert property (p_start) else $error("start bit too short");
  property p_cts;
    I_HFC_EN && $changed(I_CTS_N) |-> ##[1:4] O_CTS_EV;
  endproperty
  a_cts: assert property (p_cts) else $error("cts event missing");
endmodule
bind usp_uart usp_uart_monitor usp_uart_monitor_inst (
  .I_CLK, .I_RESETN, .I_PWR_MODE, .I_WAKE_EN, .O_WAKE, .I_HFC_EN, .I_CTS_N, .O_RTS_N,
  .O_TXD, .O_TX_READY, .O_TX_LVL, .O_RX_LVL, .I_TX_THD, .I_RX_THD, .I_DMA_TX_EN,
  .I_DMA_RX_EN, .O_DMA_TX_REQ, .O_DMA_RX_REQ, .O_CTS_EV
);
`default_nettype wire

//--- sim/usp_serial_dev.sv
// Remote serial device: drives the receive line, decodes the transmit line
`default_nettype none
module usp_serial_dev #(
  parameter int BIT_NS = 800
) (
  input wire logic i_txd,
  input wire logic [3:0] i_nbits,
  input wire logic i_par_on,
  output logic o_rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] got_q[$];
  // Line idles high between frames
  initial o_rxd = 1'b1;
  // One frame out; a low stop bit makes a broken frame on purpose
  task automatic send(input logic [7:0] d, input int nb, input logic pon, input logic pb,
    input logic stop);
    o_rxd = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < nb; i++)
    begin
      o_rxd = d[i];
      #(BIT_NS);
    end
    if (pon)
    begin
      o_rxd = pb;
      #(BIT_NS);
    end
    o_rxd = stop;
    #(BIT_NS);
    o_rxd = 1'b1;
    #(BIT_NS);
  endtask
  // Mid-bit sampling from each start edge; stop level kept with the byte
  always @(negedge i_txd)
  begin
    logic [7:0] d;
    logic p;
    d = 8'h00;
    p = 1'b0;
    #(BIT_NS / 2);
    for (int i = 0; i < int'(i_nbits); i++)
    begin
      #(BIT_NS);
      d[i] = i_txd;
    end
    if (i_par_on)
    begin
      #(BIT_NS);
      p = i_txd;
    end
    #(BIT_NS);
    got_q.push_back({i_txd, p, d});
  end
endmodule
`default_nettype wire

//--- sim/usp_uart_tb.sv
// Self-checking bench for the serial port
`default_nettype none
module usp_uart_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import usp_pkg::*;
  logic clk, rst_n, stop_long, hardware_flow_control, cts_n, tx_valid, rx_ready, dma_tx_en, dma_rx_en;
  logic [15:0] baud_div;
  logic [2:0] wake_en;
  logic [7:0] tx_data, rx_data, d;
  logic [3:0] tx_thd, rx_thd, tx_lvl, rx_lvl, nbits;
  usp_char_t char_size;
  usp_par_t parity;
  usp_pwr_t pwr;
  logic wake, rts_n, rxd, txd, tx_ready, rx_valid, rx_perr, dma_tx_req, dma_rx_req;
  logic ferr_ev, perr_ev, ovr_ev, cts_ev;
  int miscompares = 0, checks_done = 0, n_ferr = 0, n_perr = 0, n_ovr = 0, n_cts = 0;
  logic [8:0] w;
  logic [9:0] exp_q[$];
  assign nbits = {2'b00, char_size} + 4'h5;
  usp_uart usp_uart_inst (
    .I_CLK(clk), .I_RESETN(rst_n), .I_BAUD_DIV(baud_div), .I_FRAC_EN(1'b0), .I_FRAC(4'h0),
    .I_CHAR_SIZE(char_size), .I_STOP_LONG(stop_long), .I_PARITY(parity), .I_PAR_BIAS(1'b0),
    .I_PWR_MODE(pwr), .I_WAKE_EN(wake_en), .O_WAKE(wake), .I_HFC_EN(hardware_flow_control), .I_CTS_N(cts_n),
    .O_RTS_N(rts_n), .I_RXD(rxd), .O_TXD(txd), .I_TX_VALID(tx_valid), .O_TX_READY(tx_ready),
    .I_TX_DATA(tx_data), .O_RX_VALID(rx_valid), .I_RX_READY(rx_ready), .O_RX_DATA(rx_data),
    .O_RX_PERR(rx_perr), .I_TX_FLUSH(1'b0), .I_RX_FLUSH(1'b0), .O_TX_LVL(tx_lvl),
    .O_RX_LVL(rx_lvl), .I_TX_THD(tx_thd), .I_RX_THD(rx_thd), .I_DMA_TX_EN(dma_tx_en),
    .I_DMA_RX_EN(dma_rx_en), .O_DMA_TX_REQ(dma_tx_req), .O_DMA_RX_REQ(dma_rx_req),
    .O_RX_FERR_EV(ferr_ev), .O_RX_PERR_EV(perr_ev), .O_RX_OVR_EV(ovr_ev), .O_CTS_EV(cts_ev)
  );
  usp_serial_dev usp_serial_dev_inst (
    .i_txd(txd), .i_nbits(nbits), .i_par_on(parity != USP_PAR_NONE), .o_rxd(rxd)
  );
  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Event pulses counted as they pass
  always @(posedge clk)
  begin
    n_ferr += int'(ferr_ev === 1'b1);
    n_perr += int'(perr_ev === 1'b1);
    n_ovr += int'(ovr_ev === 1'b1);
    n_cts += int'(cts_ev === 1'b1);
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Reference parity bit for the current setting, data already masked
  function automatic logic pbit(input logic [7:0] v);
    case (parity)
      USP_PAR_EVEN: return ^v;
      USP_PAR_ODD: return ~^v;
      USP_PAR_MARK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  // Byte into the transmit FIFO; held until ready is seen
  task automatic wr(input logic [7:0] v);
    @(negedge clk);
    tx_valid = 1'b1;
    tx_data = v;
    for (int n = 0; n < 4000 && tx_ready !== 1'b1; n++)
      @(negedge clk);
    @(negedge clk);
    tx_valid = 1'b0;
  endtask
  // One word from the receive buffer, taken with a single ready cycle
  task automatic rd(output logic [8:0] v);
    @(negedge clk);
    for (int n = 0; n < 20000 && rx_valid !== 1'b1; n++)
      @(negedge clk);
    v = {rx_perr, rx_data};
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
  endtask
  // Waits for the far side to decode n frames, then lets the stop bits finish
  task automatic wait_dev(input int n);
    for (int i = 0; i < 20000 && usp_serial_dev_inst.got_q.size() < n; i++)
      @(negedge clk);
    repeat (40) @(negedge clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog well past the expected run of some 11000 cycles
  initial
  begin
    #2_500_000;
    miscompares++;
    summarize();
  end
  initial
  begin
    {rst_n, stop_long, hardware_flow_control, cts_n, tx_valid, rx_ready, dma_tx_en, dma_rx_en} = 8'h00;
    {wake_en, tx_data} = 11'h000;
    {tx_thd, rx_thd} = 8'h44;
    baud_div = 16'h0002;
    char_size = USP_CHAR_8;
    parity = USP_PAR_NONE;
    pwr = USP_PWR_ACTIVE;
    void'($urandom(32'heca9baa7));
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    chk(10'(txd), 10'h1);
    // Every width and parity out through the transmitter
    for (int c = 0; c < 4; c++)
      for (int m = 0; m < 5; m++)
      begin
        char_size = usp_char_t'(c);
        parity = usp_par_t'(m);
        stop_long = 1'($urandom);
        d = 8'($urandom) & (8'hff >> (3 - c));
        wr(d);
        wait_dev(1);
        chk(usp_serial_dev_inst.got_q.pop_front(), {1'b1, m != 0 && pbit(d), d});
      end
    // Every width and parity in through the receiver, one with a wrong parity bit
    for (int c = 0; c < 4; c++)
      for (int m = 0; m < 5; m++)
      begin
        char_size = usp_char_t'(c);
        parity = usp_par_t'(m);
        d = 8'($urandom) & (8'hff >> (3 - c));
        usp_serial_dev_inst.send(d, c + 5, m != 0, pbit(d) ^ (m == 1 && c == 3), 1'b1);
        rd(w);
        chk(10'(w), {1'b0, m == 1 && c == 3, d});
      end
    chk(10'(n_perr), 10'h1);
    // Low stop bit: dropped frame and a frame error
    usp_serial_dev_inst.send(8'h5a, 8, 1'b1, 1'b0, 1'b0);
    repeat (20) @(negedge clk);
    chk({9'(n_ferr), rx_valid}, 10'h2);
    // Receiver stalled: buffer and FIFO filled, then one frame too many
    parity = USP_PAR_NONE;
    hardware_flow_control = 1'b1;
    dma_rx_en = 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      d = 8'($urandom);
      if (i < 10)
        exp_q.push_back({2'b00, d});
      usp_serial_dev_inst.send(d, 8, 1'b0, 1'b0, 1'b1);
    end
    chk(10'(rx_lvl), 10'h8);
    chk(10'(rts_n), 10'h1);
    chk(10'(dma_rx_req), 10'h1);
    chk(10'(n_ovr), 10'h1);
    repeat (10)
    begin
      rd(w);
      chk(10'(w), exp_q.pop_front());
    end
    repeat (3) @(negedge clk);
    chk({8'(rx_lvl), rts_n, dma_rx_req}, 10'h0);
    // Clear-to-send held off until the transmit FIFO is full
    cts_n = 1'b1;
    dma_tx_en = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 8; i++)
    begin
      d = 8'($urandom);
      exp_q.push_back({2'b10, d});
      wr(d);
    end
    chk({tx_lvl, tx_ready, dma_tx_req, txd, 3'h0}, 10'h208);
    tx_valid = 1'b1;
    repeat (4) @(negedge clk);
    tx_valid = 1'b0;
    chk(10'(tx_lvl), 10'h8);
    // Released: a frame received while the FIFO drains out
    cts_n = 1'b0;
    d = 8'($urandom);
    usp_serial_dev_inst.send(d, 8, 1'b0, 1'b0, 1'b1);
    rd(w);
    chk(10'(w), {2'b00, d});
    wait_dev(8);
    repeat (8) chk(usp_serial_dev_inst.got_q.pop_front(), exp_q.pop_front());
    chk(10'(dma_tx_req), 10'h1);
    chk(10'(n_cts), 10'h2);
    // Deep low power: frames still stored, wake raised, no DMA request
    pwr = USP_PWR_DEEP;
    wake_en = 3'h1;
    rx_thd = 4'h1;
    repeat (3) @(negedge clk);
    chk(10'(wake), 10'h0);
    repeat (3)
    begin
      d = 8'($urandom);
      exp_q.push_back({2'b00, d});
      usp_serial_dev_inst.send(d, 8, 1'b0, 1'b0, 1'b1);
    end
    chk({wake, dma_rx_req}, 10'h2);
    pwr = USP_PWR_ACTIVE;
    @(negedge clk);
    chk(10'(wake), 10'h0);
    repeat (3)
    begin
      rd(w);
      chk(10'(w), exp_q.pop_front());
    end
    summarize();
  end
endmodule
`default_nettype wire
